/* rtl/fpm_ctrl.sv */
// shift-keying and width-modulation control: settings, mode exclusion, hop select
// assumes carrier settings arrive from elsewhere on clk_sys_in; the trigger level is asynchronous and synchronised here
`timescale 1ns/100ps
module fpm_ctrl (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  input wire fpm_pkg::fpm_cmd_t cmd_in,
  input wire fpm_pkg::fpm_carrier_t carrier_in,
  input wire logic ext_select_in,
  input wire logic signed [11:0] mod_level_in,
  input wire logic [16:0] arb_len_in,
  output fpm_pkg::fpm_status_t status_out,
  output logic hop_select_out,
  output logic err_out,
  output logic [31:0] width_dev_eff_out,
  output logic [13:0] duty_dev_eff_out,
  output logic signed [32:0] width_dev_mod_out,
  output logic signed [14:0] duty_dev_mod_out,
  output logic [4:0] decim_step_out
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic shift_carrier_ok(input fpm_pkg::fpm_carrier_shape_t s);
    shift_carrier_ok = (s == fpm_pkg::FPM_SH_SINE) || (s == fpm_pkg::FPM_SH_SQUARE) ||
                       (s == fpm_pkg::FPM_SH_RAMP) || (s == fpm_pkg::FPM_SH_ARB);
  endfunction

  function automatic logic [47:0] hop_cap(input fpm_pkg::fpm_carrier_shape_t s);
    if (s == fpm_pkg::FPM_SH_RAMP) begin
      hop_cap = fpm_pkg::FPM_HOP_MAX_RAMP;
    end else if (s == fpm_pkg::FPM_SH_ARB) begin
      hop_cap = fpm_pkg::FPM_HOP_MAX_ARB;
    end else begin
      hop_cap = fpm_pkg::FPM_HOP_MAX;
    end
  endfunction

  function automatic logic [26:0] clamp_rate(input logic [47:0] v, input logic [26:0] hi);
    if (v < 48'(fpm_pkg::FPM_RATE_MIN)) begin
      clamp_rate = fpm_pkg::FPM_RATE_MIN;
    end else if (v > 48'(hi)) begin
      clamp_rate = hi;
    end else begin
      clamp_rate = v[26:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpm_pkg::fpm_status_t cfg_q, cfg_d;
  logic err_q, err_d;
  logic hop_sel_q, hop_sel_d;
  logic [31:0] wdev_q, wdev_d;
  logic [13:0] ddev_q, ddev_d;
  logic signed [32:0] wmod_q, wmod_d;
  logic signed [14:0] dmod_q, dmod_d;
  logic [4:0] dec_q, dec_d;
  logic [47:0] cap;
  logic [31:0] wlim;
  logic [13:0] dlim;
  logic [16:0] dec_full;
  logic signed [44:0] wprod;
  logic signed [44:0] dprod;
  logic ext_lvl;
  logic shift_tick;
  logic shift_int_run;

  // ----------------------------------------------------------------
  // trigger input and internal rate
  // ----------------------------------------------------------------
  // two-flop synchroniser
  fpm_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .async_in(ext_select_in),
    .sync_out(ext_lvl)
  );

  assign shift_int_run = (cfg_q.mode == fpm_pkg::FPM_MOD_FSK) &&
                         (cfg_q.shift_source_select == fpm_pkg::FPM_SRC_INTERNAL);

  fpm_rate_gen u_rate (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .enable_in(shift_int_run),
    .rate_in(cfg_q.internal_shift_rate),
    .tick_out(shift_tick)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    err_d = 1'b0;
    cap = hop_cap(carrier_in.shape);
    if (cfg_q.hop_frequency_setting > cap) begin
      cfg_d.hop_frequency_setting = cap;
    end
    if (cfg_q.mode == fpm_pkg::FPM_MOD_FSK && !shift_carrier_ok(carrier_in.shape)) begin
      cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
    end
    if (cfg_q.mode == fpm_pkg::FPM_MOD_PWM && carrier_in.shape != fpm_pkg::FPM_SH_PULSE) begin
      cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
    end
    if (cmd_valid_in) begin
      case (cmd_in.op)
        fpm_pkg::FPM_OP_SHIFT_SRC: begin
          cfg_d.shift_source_select = fpm_pkg::fpm_src_t'(cmd_in.data[0]);
        end
        fpm_pkg::FPM_OP_HOP_FREQ: begin
          if (cmd_in.data < fpm_pkg::FPM_HOP_MIN) begin
            cfg_d.hop_frequency_setting = fpm_pkg::FPM_HOP_MIN;
            err_d = 1'b1;
          end else if (cmd_in.data > cap) begin
            cfg_d.hop_frequency_setting = cap;
            err_d = 1'b1;
          end else begin
            cfg_d.hop_frequency_setting = cmd_in.data;
          end
        end
        fpm_pkg::FPM_OP_SHIFT_RATE: begin
          cfg_d.internal_shift_rate = clamp_rate(cmd_in.data, fpm_pkg::FPM_RATE_MAX);
          err_d = (48'(cfg_d.internal_shift_rate) != cmd_in.data);
        end
        fpm_pkg::FPM_OP_SHIFT_EN: begin
          if (!cmd_in.data[0]) begin
            if (cfg_q.mode == fpm_pkg::FPM_MOD_FSK) begin
              cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
            end
          end else if (shift_carrier_ok(carrier_in.shape)) begin
            cfg_d.mode = fpm_pkg::FPM_MOD_FSK;
            cfg_d.sweep_en = 1'b0;
            cfg_d.burst_en = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
        fpm_pkg::FPM_OP_PWM_SRC: begin
          cfg_d.pwm_src = fpm_pkg::fpm_src_t'(cmd_in.data[0]);
        end
        fpm_pkg::FPM_OP_PWM_SHAPE: begin
          if (cmd_in.data[2:0] <= 3'(fpm_pkg::FPM_MS_ARBITRARY)) begin
            cfg_d.pwm_shape = fpm_pkg::fpm_mshape_t'(cmd_in.data[2:0]);
          end else begin
            err_d = 1'b1;
          end
        end
        fpm_pkg::FPM_OP_PWM_FREQ: begin
          cfg_d.pwm_freq = clamp_rate(cmd_in.data, fpm_pkg::FPM_PWMF_MAX);
          err_d = (48'(cfg_d.pwm_freq) != cmd_in.data);
        end
        fpm_pkg::FPM_OP_WIDTH_DEV: begin
          cfg_d.width_dev = cmd_in.data[31:0];
          err_d = (cmd_in.data[47:32] != 16'h0000);
        end
        fpm_pkg::FPM_OP_DUTY_DEV: begin
          cfg_d.duty_deviation_setting = cmd_in.data[13:0];
          err_d = (cmd_in.data[47:14] != 34'h0_0000_0000);
        end
        fpm_pkg::FPM_OP_PWM_EN: begin
          if (!cmd_in.data[0]) begin
            if (cfg_q.mode == fpm_pkg::FPM_MOD_PWM) begin
              cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
            end
          end else if (carrier_in.shape == fpm_pkg::FPM_SH_PULSE) begin
            cfg_d.mode = fpm_pkg::FPM_MOD_PWM;
            cfg_d.sweep_en = 1'b0;
            cfg_d.burst_en = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
        fpm_pkg::FPM_OP_OTHER_MOD: begin
          if (cmd_in.data[2:0] >= 3'(fpm_pkg::FPM_MOD_AM) &&
              cmd_in.data[2:0] <= 3'(fpm_pkg::FPM_MOD_PM)) begin
            cfg_d.mode = fpm_pkg::fpm_mode_t'(cmd_in.data[2:0]);
            cfg_d.sweep_en = 1'b0;
            cfg_d.burst_en = 1'b0;
          end else if (cmd_in.data[2:0] == 3'(fpm_pkg::FPM_MOD_NONE)) begin
            if (cfg_q.mode != fpm_pkg::FPM_MOD_FSK && cfg_q.mode != fpm_pkg::FPM_MOD_PWM) begin
              cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
            end
          end else begin
            err_d = 1'b1;
          end
        end
        fpm_pkg::FPM_OP_SWEEP_EN: begin
          cfg_d.sweep_en = cmd_in.data[0];
          if (cmd_in.data[0]) begin
            cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
          end
        end
        fpm_pkg::FPM_OP_BURST_EN: begin
          cfg_d.burst_en = cmd_in.data[0];
          if (cmd_in.data[0]) begin
            cfg_d.mode = fpm_pkg::FPM_MOD_NONE;
          end
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
    end
    cfg_d.shift_en = (cfg_d.mode == fpm_pkg::FPM_MOD_FSK);

    hop_sel_d = 1'b0;
    if (cfg_q.mode == fpm_pkg::FPM_MOD_FSK) begin
      if (cfg_q.shift_source_select == fpm_pkg::FPM_SRC_EXTERNAL) begin
        hop_sel_d = ext_lvl;
      end else begin
        hop_sel_d = hop_sel_q ^ shift_tick;
      end
    end

    wlim = (carrier_in.period_ns > carrier_in.width_ns) ?
           carrier_in.period_ns - carrier_in.width_ns : 32'h0000_0000;
    if (carrier_in.width_ns < wlim) begin
      wlim = carrier_in.width_ns;
    end
    dlim = (carrier_in.duty < fpm_pkg::FPM_DUTY_FULL) ?
           fpm_pkg::FPM_DUTY_FULL - carrier_in.duty : 14'h0000;
    if (carrier_in.duty < dlim) begin
      dlim = carrier_in.duty;
    end
    wdev_d = (cfg_q.width_dev < wlim) ? cfg_q.width_dev : wlim;
    ddev_d = (cfg_q.duty_deviation_setting < dlim) ? cfg_q.duty_deviation_setting : dlim;

    wprod = $signed({13'h0000, wdev_q}) * 45'(mod_level_in);
    dprod = $signed({31'h0000_0000, ddev_q}) * 45'(mod_level_in);
    if (cfg_q.pwm_src == fpm_pkg::FPM_SRC_EXTERNAL) begin
      wmod_d = 33'(wprod / fpm_pkg::FPM_LVL_FULL);
      dmod_d = 15'(dprod / fpm_pkg::FPM_LVL_FULL);
    end else begin
      wmod_d = $signed({1'b0, wdev_q});
      dmod_d = $signed({1'b0, ddev_q});
    end

    dec_full = (arb_len_in + fpm_pkg::FPM_ARB_ROUND) >> fpm_pkg::FPM_DEC_SHIFT;
    dec_d = 5'h01;
    if (cfg_q.pwm_src == fpm_pkg::FPM_SRC_INTERNAL &&
        cfg_q.pwm_shape == fpm_pkg::FPM_MS_ARBITRARY && dec_full > 17'h0_0001) begin
      dec_d = dec_full[4:0];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cfg_q <= '{mode: fpm_pkg::FPM_MOD_NONE, shift_en: 1'b0,
                 shift_source_select: fpm_pkg::FPM_SRC_INTERNAL,
                 hop_frequency_setting: fpm_pkg::FPM_HOP_DEF,
                 internal_shift_rate: fpm_pkg::FPM_RATE_DEF,
                 pwm_src: fpm_pkg::FPM_SRC_INTERNAL, pwm_shape: fpm_pkg::FPM_MS_SINE,
                 pwm_freq: fpm_pkg::FPM_PWMF_DEF, width_dev: fpm_pkg::FPM_WDEV_DEF,
                 duty_deviation_setting: fpm_pkg::FPM_DDEV_DEF,
                 sweep_en: 1'b0, burst_en: 1'b0};
      err_q <= 1'b0;
      hop_sel_q <= 1'b0;
      wdev_q <= '0;
      ddev_q <= '0;
      wmod_q <= '0;
      dmod_q <= '0;
      dec_q <= 5'h01;
    end else begin
      cfg_q <= cfg_d;
      err_q <= err_d;
      hop_sel_q <= hop_sel_d;
      wdev_q <= wdev_d;
      ddev_q <= ddev_d;
      wmod_q <= wmod_d;
      dmod_q <= dmod_d;
      dec_q <= dec_d;
    end
  end

  assign status_out = cfg_q;
  assign hop_select_out = hop_sel_q;
  assign err_out = err_q;
  assign width_dev_eff_out = wdev_q;
  assign duty_dev_eff_out = ddev_q;
  assign width_dev_mod_out = wmod_q;
  assign duty_dev_mod_out = dmod_q;
  assign decim_step_out = dec_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  property p_carrier_ok;
    cfg_q.mode == fpm_pkg::FPM_MOD_FSK |-> shift_carrier_ok($past(carrier_in.shape));
  endproperty
  a_carrier_ok: assert property (p_carrier_ok) else $error("shift on bad carrier");

  property p_hop_cap;
    ##1 cfg_q.hop_frequency_setting <= hop_cap($past(carrier_in.shape)) &&
        cfg_q.hop_frequency_setting >= fpm_pkg::FPM_HOP_MIN;
  endproperty
  a_hop_cap: assert property (p_hop_cap) else $error("hop out of range");

  property p_rate_rng;
    cfg_q.internal_shift_rate >= fpm_pkg::FPM_RATE_MIN &&
    cfg_q.internal_shift_rate <= fpm_pkg::FPM_RATE_MAX;
  endproperty
  a_rate_rng: assert property (p_rate_rng) else $error("rate out of range");

  property p_int_toggle;
    shift_int_run && $past(shift_int_run) && hop_sel_q != $past(hop_sel_q) |-> $past(shift_tick);
  endproperty
  a_int_toggle: assert property (p_int_toggle) else $error("toggle without tick");

  property p_ext_level;
    cfg_q.mode == fpm_pkg::FPM_MOD_FSK &&
    cfg_q.shift_source_select == fpm_pkg::FPM_SRC_EXTERNAL |=> hop_sel_q == $past(ext_lvl);
  endproperty
  a_ext_level: assert property (p_ext_level) else $error("hop select not level");

  property p_ext_no_tick;
    cfg_q.shift_source_select == fpm_pkg::FPM_SRC_EXTERNAL [*2] |-> !shift_tick;
  endproperty
  a_ext_no_tick: assert property (p_ext_no_tick) else $error("rate used when external");

  property p_en_readback;
    cfg_q.shift_en == (cfg_q.mode == fpm_pkg::FPM_MOD_FSK);
  endproperty
  a_en_readback: assert property (p_en_readback) else $error("enable readback wrong");

  property p_no_sweep;
    cfg_q.mode == fpm_pkg::FPM_MOD_FSK || cfg_q.mode == fpm_pkg::FPM_MOD_PWM |->
      !cfg_q.sweep_en && !cfg_q.burst_en;
  endproperty
  a_no_sweep: assert property (p_no_sweep) else $error("sweep with modulation");

  property p_pwm_pulse;
    cfg_q.mode == fpm_pkg::FPM_MOD_PWM |-> $past(carrier_in.shape) == fpm_pkg::FPM_SH_PULSE;
  endproperty
  a_pwm_pulse: assert property (p_pwm_pulse) else $error("width mode off pulse");

  property p_wdev_lim;
    ##1 wdev_q <= $past(carrier_in.width_ns) && wdev_q <= $past(cfg_q.width_dev);
  endproperty
  a_wdev_lim: assert property (p_wdev_lim) else $error("width deviation over limit");

  property p_reset_def;
    $rose(resetn_in) |-> cfg_q.mode == fpm_pkg::FPM_MOD_NONE &&
      cfg_q.shift_source_select == fpm_pkg::FPM_SRC_INTERNAL &&
      cfg_q.pwm_shape == fpm_pkg::FPM_MS_SINE;
  endproperty
  a_reset_def: assert property (p_reset_def) else $error("bad reset defaults");

endmodule

/* rtl/fpm_pkg.sv */
// shared types and constants for the shift-keying / width-modulation control
// assumes a single 40 MHz system clock and synchronous active-low reset
package fpm_pkg;

  // ----------------------------------------------------------------
  // clock and widths
  // ----------------------------------------------------------------
  localparam logic [31:0] FPM_CLK_HZ = 32'h0262_5a00;
  localparam int FPM_HOP_W = 48;
  localparam int FPM_RATE_W = 27;
  localparam int FPM_DEV_W = 32;
  localparam int FPM_DUTY_W = 14;
  localparam int FPM_LVL_W = 12;
  localparam int FPM_ALEN_W = 17;
  localparam int FPM_DEC_W = 5;
  localparam int FPM_DEC_SHIFT = 12;
  // half a shift period in rate units (mHz) times clock cycles
  localparam logic [35:0] FPM_HALF_ACC = 36'(64'(FPM_CLK_HZ) * 64'h1f4);

  // ----------------------------------------------------------------
  // limits and reset values (hop in uHz, rates in mHz, widths in ns)
  // ----------------------------------------------------------------
  localparam logic [47:0] FPM_HOP_MIN = 48'h0000_0000_0001;
  localparam logic [47:0] FPM_HOP_MAX = 48'h1230_9ce5_4000;
  localparam logic [47:0] FPM_HOP_MAX_RAMP = 48'h002e_90ed_d000;
  localparam logic [47:0] FPM_HOP_MAX_ARB = 48'h0574_fbde_6000;
  localparam logic [47:0] FPM_HOP_DEF = 48'h0000_05f5_e100;
  localparam logic [26:0] FPM_RATE_MIN = 27'h000_0002;
  localparam logic [26:0] FPM_RATE_MAX = 27'h5f5_e100;
  localparam logic [26:0] FPM_RATE_DEF = 27'h000_2710;
  localparam logic [26:0] FPM_PWMF_MAX = 27'h131_2d00;
  localparam logic [26:0] FPM_PWMF_DEF = 27'h000_2710;
  localparam logic [31:0] FPM_WDEV_DEF = 32'h0000_2710;
  localparam logic [13:0] FPM_DDEV_DEF = 14'h0064;
  localparam logic [13:0] FPM_DUTY_FULL = 14'h2710;
  localparam logic [16:0] FPM_ARB_ROUND = 17'h0_0fff;
  localparam logic signed [44:0] FPM_LVL_FULL = 45'sh0000_0000_07ff;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FPM_SH_SINE, FPM_SH_SQUARE, FPM_SH_RAMP, FPM_SH_PULSE, FPM_SH_NOISE, FPM_SH_DC, FPM_SH_ARB
  } fpm_carrier_shape_t;
  typedef enum logic [2:0] {
    FPM_MOD_NONE, FPM_MOD_AM, FPM_MOD_FM, FPM_MOD_PM, FPM_MOD_FSK, FPM_MOD_PWM
  } fpm_mode_t;
  typedef enum logic {FPM_SRC_INTERNAL, FPM_SRC_EXTERNAL} fpm_src_t;
  typedef enum logic [2:0] {
    FPM_MS_SINE, FPM_MS_SQUARE, FPM_MS_RISING_RAMP, FPM_MS_FALLING_RAMP_SHAPE,
    FPM_MS_TRIANGLE, FPM_MS_NOISE, FPM_MS_ARBITRARY
  } fpm_mshape_t;
  typedef enum logic [3:0] {
    FPM_OP_SHIFT_SRC, FPM_OP_HOP_FREQ, FPM_OP_SHIFT_RATE, FPM_OP_SHIFT_EN,
    FPM_OP_PWM_SRC, FPM_OP_PWM_SHAPE, FPM_OP_PWM_FREQ, FPM_OP_WIDTH_DEV,
    FPM_OP_DUTY_DEV, FPM_OP_PWM_EN, FPM_OP_OTHER_MOD, FPM_OP_SWEEP_EN, FPM_OP_BURST_EN
  } fpm_op_t;

  // ----------------------------------------------------------------
  // command, carrier and status structures
  // ----------------------------------------------------------------
  typedef struct packed {
    fpm_op_t op;
    logic [47:0] data;
  } fpm_cmd_t;
  typedef struct packed {
    fpm_carrier_shape_t shape;
    logic [31:0] width_ns;
    logic [31:0] period_ns;
    logic [13:0] duty;
  } fpm_carrier_t;
  typedef struct packed {
    fpm_mode_t mode;
    logic shift_en;
    fpm_src_t shift_source_select;
    logic [47:0] hop_frequency_setting;
    logic [26:0] internal_shift_rate;
    fpm_src_t pwm_src;
    fpm_mshape_t pwm_shape;
    logic [26:0] pwm_freq;
    logic [31:0] width_dev;
    logic [13:0] duty_deviation_setting;
    logic sweep_en;
    logic burst_en;
  } fpm_status_t;

endpackage

/* rtl/fpm_sync.sv */
// two-flop level synchroniser
// assumes the input may change at any time relative to clk_sys_in
`timescale 1ns/100ps
module fpm_sync (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

/* rtl/fpm_rate_gen.sv */
// fractional rate generator: one tick per half period of the programmed rate
// assumes rate_in in mHz, at most a small fraction of the clock
`timescale 1ns/100ps
module fpm_rate_gen (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic [fpm_pkg::FPM_RATE_W-1:0] rate_in,
  output logic tick_out
);

  logic [35:0] acc_q, acc_d;
  logic [35:0] sum;
  logic tick_q, tick_d;

  always_comb begin
    sum = acc_q + 36'(rate_in);
    acc_d = sum;
    tick_d = 1'b0;
    if (!enable_in) begin
      acc_d = '0;
    end else if (sum >= fpm_pkg::FPM_HALF_ACC) begin
      acc_d = sum - fpm_pkg::FPM_HALF_ACC;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

endmodule

/* verification/fpm_sel_model.sv */
// far-side model: drives the external frequency-select level
// assumes run_in is high only while the bench wants toggling
`timescale 1ns/100ps
module fpm_sel_model #(parameter int HALF = 24) (
  input wire logic clk_sys_in,
  input wire logic run_in,
  output logic sel_out
);
  // ------------------------------------------------------------
  // toggle generator
  // ------------------------------------------------------------
  int cnt = 0;
  initial sel_out = 1'b0;
  // level source, at most 1 MHz
  always @(posedge clk_sys_in) begin
    cnt <= run_in ? (cnt == HALF - 1 ? 0 : cnt + 1) : 0;
    if (run_in && cnt == HALF - 1) sel_out <= #1 ~sel_out;
  end
endmodule

/* verification/fpm_ctrl_tb_top.sv */
// self-checking bench for fpm_ctrl
// assumes fpm_pkg and fpm_sel_model are compiled first
`timescale 1ns/100ps
module fpm_ctrl_tb_top;
  // ------------------------------------------------------------
  // signals and helpers
  // ------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  fpm_pkg::fpm_cmd_t cmd_in = '0;
  fpm_pkg::fpm_carrier_t carrier_in = '0;
  logic external_source, run = 1'b0, hop_sel, err;
  logic signed [11:0] mod_level_in = 12'h000;
  logic [16:0] arb_len_in = 17'h0_0100;
  fpm_pkg::fpm_status_t st;
  logic [31:0] wd_eff, seed = 32'h0000_4b07;
  logic [13:0] dd_eff;
  logic signed [32:0] wd_mod;
  logic signed [14:0] dd_mod;
  logic [4:0] decim;
  int num_errors = 0, total_checks = 0, n;
  typedef struct {int k; logic [47:0] v;} fpm_note_t;
  fpm_note_t q[$];
  string nm[14] = '{"mode", "err", "shift_en", "sweep_burst", "hop", "rate", "duty_eff",
    "duty_mod", "decim", "sources", "pwm_shape", "pwm_freq", "width_eff", "width_mod"};
  event chk_ev;
  always #12.5 clk_sys_in = ~clk_sys_in;
  fpm_ctrl fpm_ctrl_inst (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .carrier_in(carrier_in),
    .ext_select_in(external_source), .mod_level_in(mod_level_in), .arb_len_in(arb_len_in),
    .status_out(st), .hop_select_out(hop_sel), .err_out(err), .width_dev_eff_out(wd_eff),
    .duty_dev_eff_out(dd_eff), .width_dev_mod_out(wd_mod), .duty_dev_mod_out(dd_mod),
    .decim_step_out(decim));
  fpm_sel_model fpm_sel_model_inst (.clk_sys_in(clk_sys_in), .run_in(run), .sel_out(external_source));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [47:0] pick(int k);
    case (k)
      0: return 48'(st.mode);
      1: return 48'(err);
      2: return 48'(st.shift_en);
      3: return 48'({st.sweep_en, st.burst_en});
      4: return st.hop_frequency_setting;
      5: return 48'(st.internal_shift_rate);
      6: return 48'(dd_eff);
      7: return 48'(dd_mod);
      8: return 48'(decim);
      9: return 48'({st.shift_source_select, st.pwm_src});
      10: return 48'(st.pwm_shape);
      11: return 48'(st.pwm_freq);
      12: return 48'(wd_eff);
      default: return 48'(wd_mod);
    endcase
  endfunction
  task automatic chk(string s, logic [47:0] seen, logic [47:0] e);
    total_checks++;
    if (seen !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, seen);
    end
  endtask
  always @(chk_ev) while (q.size() > 0) begin
    chk(nm[q[0].k], pick(q[0].k), q[0].v);
    void'(q.pop_front());
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic note(int k, logic [47:0] v);
    q.push_back('{k, v});
  endtask
  task automatic fire();
    ->chk_ev;
    #1;
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge clk_sys_in);
    #2;
  endtask
  task automatic cf(int op, logic [47:0] d, logic e, int k, logic [47:0] v);
    @(posedge clk_sys_in);
    #2;
    cmd_valid_in = 1'b1;
    cmd_in = '{fpm_pkg::fpm_op_t'(op), d};
    cyc(1);
    cmd_valid_in = 1'b0;
    note(1, 48'(e));
    note(k, v);
    fire();
  endtask
  task automatic gap(ref logic s, output int c);
    logic h;
    h = s;
    c = 0;
    while (s === h) begin
      cyc(1);
      c++;
      if (c > 1000) begin
        num_errors++;
        test_done();
      end
    end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(6);
    resetn_in = 1'b1;
    note(0, 0);
    note(2, 0);
    note(9, 0);
    note(4, 48'h0000_05f5_e100);
    note(5, 48'h2710);
    note(10, 0);
    note(11, 48'h2710);
    fire();
    $display("test defaults done");
    for (int s = 0; s < 7; s++) begin
      carrier_in.shape = fpm_pkg::fpm_carrier_shape_t'(s);
      cf(3, 1, s inside {3, 4, 5}, 2, !(s inside {3, 4, 5}));
      cf(3, 0, 0, 2, 0);
    end
    carrier_in.shape = fpm_pkg::FPM_SH_RAMP;
    cf(1, fpm_pkg::FPM_HOP_MAX_ARB, 1, 4, fpm_pkg::FPM_HOP_MAX_RAMP);
    carrier_in.shape = fpm_pkg::FPM_SH_ARB;
    cf(1, 48'hffff_ffff_ffff, 1, 4, fpm_pkg::FPM_HOP_MAX_ARB);
    carrier_in.shape = fpm_pkg::FPM_SH_SINE;
    cf(1, 0, 1, 4, 1);
    seed = rnd();
    cf(1, {16'h0000, seed}, 0, 4, {16'h0000, seed});
    cf(2, 1, 1, 5, 2);
    cf(2, 48'h5f5_e101, 1, 5, fpm_pkg::FPM_RATE_MAX);
    cf(10, 1, 0, 0, 1);
    cf(3, 1, 0, 0, 4);
    for (int o = 11; o < 13; o++) begin
      cf(o, 1, 0, 3, o == 11 ? 2 : 1);
      cf(3, 1, 0, 3, 0);
    end
    $display("test settings done");
    gap(hop_sel, n);
    gap(hop_sel, n);
    chk("hop_high", n, 200);
    gap(hop_sel, n);
    chk("hop_low", n, 200);
    cf(0, 1, 0, 9, 2);
    run = 1'b1;
    for (int i = 0; i < 6; i++) begin
      gap(external_source, n);
      cyc(1);
      chk("sync_delay", hop_sel, !external_source);
      cyc(3);
      chk("hop_follow", hop_sel, external_source);
    end
    run = 1'b0;
    $display("test shift done");
    cf(9, 1, 1, 0, 4);
    carrier_in = '{fpm_pkg::FPM_SH_PULSE, 32'h64, 32'h3e8, 14'h07d0};
    cf(10, 2, 0, 0, 2);
    cf(9, 1, 0, 0, 5);
    cf(8, 48'h0bb8, 0, 2, 0);
    cf(7, 48'h01f4, 0, 2, 0);
    cyc(2);
    note(6, 48'h07d0);
    note(12, 48'h64);
    fire();
    cf(4, 1, 0, 9, 3);
    mod_level_in = 12'h7ff;
    cyc(3);
    note(7, 48'h07d0);
    note(13, 48'h64);
    fire();
    mod_level_in = 12'h400;
    cyc(3);
    note(7, 48'h03e8);
    note(13, 48'h32);
    fire();
    mod_level_in = 12'h000;
    cyc(3);
    note(7, 0);
    note(13, 0);
    fire();
    cf(4, 0, 0, 9, 2);
    arb_len_in = 17'h0_2710;
    for (int s = 0; s < 7; s++) cf(5, s, 0, 10, s);
    cyc(2);
    note(8, 3);
    fire();
    cf(10, 3, 0, 0, 3);
    cf(15, 0, 1, 0, 3);
    cf(10, 0, 0, 0, 0);
    $display("test width done");
    test_done();
  end
endmodule
